/* File: pkg/flash_fetch_defines.vh */
// Overview of operation
// - 16-bit mode fetch takes one cycle
// - 32-bit fetch, divider zero: two cycles
// - divider nonzero: 32-bit fetch one cycle
// - dead time before every flash data access
// - branch: one decode, four refill if zero
// - register-only instruction adds no cycles
// - load: fetch, one dead, word 2/half 1
// - multiple load N: N dead, 2N access
// - word write 50 us; store 2, half 1
// - execution stalls during erase or write
// - page 512 bytes, erase takes 20 ms
// - enabled interrupt aborts erase or write
// - abort completes in about ten cycles
// - top 2 kB reserved for boot kernel
// - 30 ms watchdog while kernel runs
// - download mode changes only through reset
// - signature or checksum gates user code
// - test reset high: always run user
// - debug port blocked during kernel
// - register space is top 4 kB
// - 32-bit access to any register, little-endian
// - 16-bit write zeroes upper half
`ifndef FLASH_FETCH_DEFINES_VH
`define FLASH_FETCH_DEFINES_VH
`define CLK_HZ 40000000
`define FETCH_16_CYC 4'h1
`define FETCH_32_CYC 4'h2
`define DECODE_CYC 4'h1
`define REFILL_CYC 4'h4
`define DEAD_CYC 4'h1
`define WORD_ACC_CYC 4'h2
`define HALF_ACC_CYC 4'h1
`define MULTI_MAX 5'h10
`define WRITE_US 50
`define WRITE_CYC ((`WRITE_US * 40) )
`define ERASE_MS 20
`define ERASE_CYC (`ERASE_MS * 40000)
`define WDOG_MS 30
`define WDOG_CYC (`WDOG_MS * 40000)
`define ABORT_CYC 10
`define PAGE_BYTES 512
`define KERNEL_BASE 32'h00017800
`define MMR_BASE 32'hFFFFF000
`define SIG_ADDR 32'h00000014
`define SIG_VALUE 32'h27011970
`define OP_ALU 3'h0
`define OP_LD 3'h1
`define OP_LDH 3'h2
`define OP_LDM 3'h3
`define OP_STR 3'h4
`define OP_STRH 3'h5
`define OP_STM 3'h6
`define OP_BRANCH 3'h7
`endif

/* File: hdl/cycle_timer.v */
`timescale 1ns/1ps
`default_nettype none
// loadable down counter, pulses done_o when it reaches one
module cycle_timer #(
  parameter W = 24
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire load_i,
  input wire [W-1:0] count_i,
  input wire stop_i,
  output reg busy_o,
  output reg done_o
);
  reg [W-1:0] cnt_r;
  // ================================================================
  // counter
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= {W{1'b0}};
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        cnt_r <= count_i;
        busy_o <= 1'b1;
      end else if (stop_i) begin
        busy_o <= 1'b0;
      end else if (busy_o) begin
        if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // cycle_timer
`default_nettype wire

/* File: hdl/mmr_lane.v */
`timescale 1ns/1ps
`default_nettype none
`include "flash_fetch_defines.vh"
// lane merge for register writes and read return
module mmr_lane (
  input wire [31:0] addr_i,
  input wire [31:0] old_i,
  input wire [31:0] wdata_i,
  input wire half_i,
  output wire hit_o,
  output wire [31:0] wr_o,
  output wire [31:0] rd_o
);
  // top 4 kB decode
  assign hit_o = (addr_i & `MMR_BASE) == `MMR_BASE;
  // full word written as is, halfword zero extends
  assign wr_o = half_i ? {16'h0000, wdata_i[15:0]} : wdata_i;
  // halfword read sees only low half, little-endian
  assign rd_o = half_i ? {16'h0000, old_i[15:0]} : old_i;
  wire unused_ok = ^old_i[31:16];
endmodule // mmr_lane
`default_nettype wire

/* File: hdl/flash_fetch_boot_mmr_access.v */
`timescale 1ns/1ps
`default_nettype none
`include "flash_fetch_defines.vh"
module flash_fetch_boot_mmr_access #(
  parameter WRITE_CYC = `WRITE_CYC,
  parameter ERASE_CYC = `ERASE_CYC,
  parameter WDOG_CYC = `WDOG_CYC,
  parameter MMR_WORDS = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  // instruction issue from the core
  input wire req_i,
  input wire [2:0] op_i,
  input wire [4:0] nregs_i,
  input wire from_flash_i,
  input wire mode16_i,
  input wire [2:0] core_clock_divider_i,
  output reg ack_o,
  output reg stall_o,
  // flash program and erase
  input wire erase_i,
  input wire irq_i,
  output reg flash_busy_o,
  output reg abort_o,
  // register access
  input wire mmr_we_i,
  input wire mmr_re_i,
  input wire mmr_half_i,
  input wire [31:0] mmr_addr_i,
  input wire [31:0] mmr_wdata_i,
  output reg [31:0] mmr_rdata_o,
  output reg mmr_hit_o,
  // boot
  input wire test_reset_i,
  input wire [31:0] sig_word_i,
  input wire [31:0] page0_sum_i,
  input wire kernel_done_i,
  output reg kernel_run_o,
  output reg user_run_o,
  output reg download_o,
  output reg debug_en_o,
  output reg wdog_rst_o,
  output reg [31:0] kernel_base_o
);
  // ================================================================
  // sequencer states
  localparam S_IDLE = 3'h0;
  localparam S_WAIT = 3'h1;
  localparam S_PROG = 3'h2;
  localparam S_ABORT = 3'h3;
  localparam S_BOOT = 3'h4;

  reg [2:0] state_r;
  reg [7:0] wait_r;
  reg [5:0] writes_r;
  reg [3:0] abort_r;
  reg prog_load_r;
  reg [23:0] prog_cnt_r;
  reg wd_load_r;
  reg [31:0] mmr_r [0:MMR_WORDS-1];
  wire prog_busy;
  wire prog_done;
  wire wd_busy;
  wire wd_done;
  wire lane_hit;
  wire [31:0] lane_wr;
  wire [31:0] lane_rd;
  wire [3:0] idx;
  reg [7:0] cost;

  // fetch cost for the current mode and divider
  function [3:0] fetch_cyc;
    input m16;
    input [2:0] div;
    begin
      if (m16)
        fetch_cyc = `FETCH_16_CYC;
      else if (div == 3'h0)
        fetch_cyc = `FETCH_32_CYC;
      else
        fetch_cyc = `FETCH_16_CYC;
    end
  endfunction

  assign idx = mmr_addr_i[5:2];

  // ================================================================
  // timers
  cycle_timer #(.W(24)) u_prog (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(prog_load_r),
    .count_i(prog_cnt_r),
    .stop_i(irq_i && state_r == S_PROG),
    .busy_o(prog_busy),
    .done_o(prog_done)
  );

  cycle_timer #(.W(24)) u_wdog (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(wd_load_r),
    .count_i(WDOG_CYC[23:0]),
    .stop_i(kernel_done_i),
    .busy_o(wd_busy),
    .done_o(wd_done)
  );

  mmr_lane u_lane (
    .addr_i(mmr_addr_i),
    .old_i(mmr_r[idx]),
    .wdata_i(mmr_wdata_i),
    .half_i(mmr_half_i),
    .hit_o(lane_hit),
    .wr_o(lane_wr),
    .rd_o(lane_rd)
  );

  // ================================================================
  // cycle cost of one instruction
  always @* begin
    cost = {4'h0, fetch_cyc(mode16_i, core_clock_divider_i)};
    if (from_flash_i) begin
      case (op_i)
        `OP_ALU: cost = cost;
        `OP_LD: cost = cost + `DEAD_CYC + `WORD_ACC_CYC;
        `OP_LDH: cost = cost + `DEAD_CYC + `HALF_ACC_CYC;
        // N dead cycles plus two access cycles per register
        `OP_LDM: cost = cost + {2'b00, nregs_i, 1'b0}
          + {3'h0, nregs_i};
        `OP_STR, `OP_STRH: cost = cost + `DEAD_CYC;
        `OP_STM: cost = cost + {3'h0, nregs_i};
        `OP_BRANCH: cost = cost + `DECODE_CYC +
          ((core_clock_divider_i == 3'h0) ? `REFILL_CYC : 4'h0);
        default: cost = cost;
      endcase
    end
  end

  // ================================================================
  // main sequencer
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= S_BOOT;
      wait_r <= 8'h00;
      writes_r <= 6'h00;
      abort_r <= 4'h0;
      prog_load_r <= 1'b0;
      prog_cnt_r <= 24'h000000;
      wd_load_r <= 1'b1;
      ack_o <= 1'b0;
      stall_o <= 1'b1;
      flash_busy_o <= 1'b0;
      abort_o <= 1'b0;
      kernel_run_o <= 1'b1;
      user_run_o <= 1'b0;
      download_o <= 1'b0;
      debug_en_o <= 1'b0;
      wdog_rst_o <= 1'b0;
      kernel_base_o <= `KERNEL_BASE;
    end else begin
      ack_o <= 1'b0;
      abort_o <= 1'b0;
      prog_load_r <= 1'b0;
      wd_load_r <= 1'b0;
      wdog_rst_o <= wd_done;
      case (state_r)
        S_BOOT: begin
          stall_o <= 1'b1;
          debug_en_o <= 1'b0;
          if (kernel_done_i) begin
            kernel_run_o <= 1'b0;
            debug_en_o <= 1'b1;
            stall_o <= 1'b0;
            state_r <= S_IDLE;
            // decided once per reset, never left without one
            if (test_reset_i) begin
              user_run_o <= 1'b1;
            end else if (sig_word_i == `SIG_VALUE ||
                         sig_word_i == page0_sum_i) begin
              user_run_o <= 1'b1;
            end else begin
              download_o <= 1'b1;
            end
          end
        end
        S_IDLE: begin
          if (erase_i) begin
            prog_cnt_r <= ERASE_CYC[23:0];
            prog_load_r <= 1'b1;
            flash_busy_o <= 1'b1;
            stall_o <= 1'b1;
            writes_r <= 6'h00;
            state_r <= S_PROG;
          end else if (req_i && !ack_o && from_flash_i &&
                       (op_i == `OP_STR || op_i == `OP_STRH ||
                        op_i == `OP_STM)) begin
            writes_r <= (op_i == `OP_STRH) ? 6'h01 :
              (op_i == `OP_STR) ? 6'h02 : {nregs_i, 1'b0};
            stall_o <= 1'b1;
            wait_r <= cost;
            state_r <= S_WAIT;
          end else if (req_i && !ack_o) begin
            // request still high in the ack cycle is the old one
            stall_o <= (cost > 8'h01);
            wait_r <= cost;
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (wait_r <= 8'h01) begin
            if (writes_r != 6'h00) begin
              prog_cnt_r <= WRITE_CYC[23:0];
              prog_load_r <= 1'b1;
              flash_busy_o <= 1'b1;
              state_r <= S_PROG;
            end else begin
              ack_o <= 1'b1;
              stall_o <= 1'b0;
              state_r <= S_IDLE;
            end
          end else begin
            wait_r <= wait_r - 8'h01;
          end
        end
        S_PROG: begin
          if (irq_i) begin
            abort_r <= 4'h1;
            state_r <= S_ABORT;
          end else if (prog_done) begin
            if (writes_r > 6'h01) begin
              writes_r <= writes_r - 6'h01;
              prog_load_r <= 1'b1;
            end else begin
              writes_r <= 6'h00;
              flash_busy_o <= 1'b0;
              stall_o <= 1'b0;
              // a page erase answers no instruction, only stores ack
              ack_o <= (writes_r != 6'h00);
              state_r <= S_IDLE;
            end
          end
        end
        S_ABORT: begin
          if (abort_r == `ABORT_CYC - 1) begin
            abort_o <= 1'b1;
            flash_busy_o <= 1'b0;
            stall_o <= 1'b0;
            writes_r <= 6'h00;
            state_r <= S_IDLE;
          end else begin
            abort_r <= abort_r + 4'h1;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ================================================================
  // register window
  integer i;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < MMR_WORDS; i = i + 1)
        mmr_r[i] <= 32'h00000000;
      mmr_rdata_o <= 32'h00000000;
      mmr_hit_o <= 1'b0;
    end else begin
      mmr_hit_o <= lane_hit && (mmr_we_i || mmr_re_i);
      if (lane_hit && mmr_we_i)
        mmr_r[idx] <= lane_wr;
      if (lane_hit && mmr_re_i)
        mmr_rdata_o <= lane_rd;
      else
        mmr_rdata_o <= 32'h00000000;
    end
  end

  wire unused_ok = wd_busy ^ prog_busy;
endmodule // flash_fetch_boot_mmr_access
`default_nettype wire

/* File: verif/ffb_chk_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_fetch_defines.vh"
// ==========
// port checker
module ffb_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic irq_i,
  input wire logic mmr_re_i,
  input wire logic mmr_half_i,
  input wire logic [31:0] mmr_addr_i,
  input wire logic flash_busy_o,
  input wire logic abort_o,
  input wire logic mmr_hit_o,
  input wire logic [31:0] mmr_rdata_o,
  input wire logic kernel_run_o,
  input wire logic user_run_o,
  input wire logic download_o,
  input wire logic debug_en_o,
  input wire logic wdog_rst_o,
  input wire logic [31:0] kernel_base_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  base_const_a: assert property (kernel_base_o == `KERNEL_BASE)
    else $error("kernel base moved");
  dbg_block_a: assert property (kernel_run_o |-> !debug_en_o)
    else $error("debug open in kernel");
  wdog_off_a: assert property (!kernel_run_o && $past(!kernel_run_o)
    |-> !wdog_rst_o)
    else $error("watchdog after kernel");
  boot_hold_a: assert property (!kernel_run_o && $past(!kernel_run_o)
    |-> $stable(download_o) && $stable(user_run_o))
    else $error("boot mode changed without reset");
  run_excl_a: assert property (!(user_run_o && download_o))
    else $error("user and download together");
  hit_range_a: assert property (mmr_hit_o
    |-> $past(mmr_addr_i[31:12]) == 20'hFFFFF)
    else $error("register hit outside top space");
  half_read_a: assert property (mmr_hit_o && $past(mmr_re_i && mmr_half_i)
    |-> mmr_rdata_o[31:16] == 16'h0000)
    else $error("half read upper bits set");
  abort_time_a: assert property (irq_i && flash_busy_o
    |-> ##[1:12] abort_o)
    else $error("abort too slow");
  abort_idle_a: assert property (abort_o |-> ##[0:1] !flash_busy_o)
    else $error("flash busy after abort");
  // main scenarios
  cover property (abort_o);
  cover property (download_o);
  cover property (user_run_o);
  cover property (wdog_rst_o);
endmodule // ffb_chk
bind flash_fetch_boot_mmr_access ffb_chk chk_i (.clk_i, .rst_n_i, .irq_i,
  .mmr_re_i, .mmr_half_i, .mmr_addr_i, .flash_busy_o, .abort_o, .mmr_hit_o,
  .mmr_rdata_o, .kernel_run_o, .user_run_o, .download_o, .debug_en_o,
  .wdog_rst_o, .kernel_base_o);
`default_nettype wire

/* File: verif/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// core side: holds a request until ack, counts edges
module core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic ack_i,
  output logic req_o,
  output logic [15:0] lat_o,
  output logic done_o
);
  // next request only after the previous ack
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_o <= 1'b0;
      lat_o <= 16'h0000;
      done_o <= 1'b0;
    end else if (go_i && !req_o) begin
      req_o <= 1'b1;
      lat_o <= 16'h0000;
      done_o <= 1'b0;
    end else if (req_o && ack_i) begin
      req_o <= 1'b0;
      done_o <= 1'b1;
    end else if (req_o) begin
      lat_o <= lat_o + 16'h0001;
    end
  end
endmodule // core_model
`default_nettype wire

/* File: verif/flash_fetch_boot_mmr_access_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_fetch_defines.vh"
module flash_fetch_boot_mmr_access_tb;
  localparam int W = 20;
  logic clk_i = 1'b0, rst_n_i = 1'b0, go = 1'b0, done, req_i, ack_o, stall_o;
  logic [2:0] op_i = 3'h0, core_clock_divider_i = 3'h0;
  logic [4:0] nregs_i = 5'h00;
  logic from_flash_i = 1'b1, mode16_i = 1'b1, erase_i = 1'b0, irq_i = 1'b0;
  logic flash_busy_o, abort_o, mmr_hit_o, kernel_run_o, user_run_o;
  logic mmr_we_i = 1'b0, mmr_re_i = 1'b0, mmr_half_i = 1'b0;
  logic [31:0] mmr_addr_i = 32'h0, mmr_wdata_i = 32'h0, mmr_rdata_o;
  logic test_reset_i = 1'b0, kernel_done_i = 1'b0, download_o, debug_en_o;
  logic [31:0] sig_word_i = 32'h0, page0_sum_i = 32'h0, kernel_base_o;
  logic wdog_rst_o, seen;
  logic [15:0] lat;
  int error_cnt = 0, checks = 0, cyc = 0, n;
  always #12.5 clk_i = ~clk_i;
  core_model cm (.clk_i, .rst_n_i, .go_i(go), .ack_i(ack_o), .req_o(req_i),
    .lat_o(lat), .done_o(done));
  flash_fetch_boot_mmr_access #(.WRITE_CYC(W), .ERASE_CYC(50),
    .WDOG_CYC(100)) uut (.clk_i, .rst_n_i, .req_i, .op_i, .nregs_i,
    .from_flash_i, .mode16_i, .core_clock_divider_i, .ack_o, .stall_o,
    .erase_i, .irq_i, .flash_busy_o, .abort_o, .mmr_we_i, .mmr_re_i,
    .mmr_half_i, .mmr_addr_i, .mmr_wdata_i, .mmr_rdata_o, .mmr_hit_o,
    .test_reset_i, .sig_word_i, .page0_sum_i, .kernel_done_i, .kernel_run_o,
    .user_run_o, .download_o, .debug_en_o, .wdog_rst_o, .kernel_base_o);
  // ==========
  // shared tasks
  task finish_test;
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task issue(input logic [2:0] o, input logic [4:0] k, input logic m,
    input logic [2:0] d);
    int wn;
    @(negedge clk_i);
    {op_i, nregs_i, mode16_i, core_clock_divider_i} = {o, k, m, d};
    go = 1'b1;
    @(negedge clk_i);
    go = 1'b0;
    for (wn = 0; wn < 400 && done !== 1'b1; wn++) @(negedge clk_i);
  endtask
  task run(input logic [2:0] o, input logic [4:0] k, input logic m,
    input logic [2:0] d, input logic [31:0] e);
    issue(o, k, m, d);
    // latency also counts the edge at which the request is taken
    chk({16'h0, lat}, e + 32'h1);
  endtask
  task macc(input logic we, input logic [31:0] a, input logic [31:0] v,
    input logic h);
    @(negedge clk_i);
    {mmr_we_i, mmr_re_i, mmr_addr_i, mmr_wdata_i, mmr_half_i} = {we, !we, a, v, h};
    @(negedge clk_i);
    {mmr_we_i, mmr_re_i} = 2'b00;
  endtask
  task boot(input logic t, input logic [31:0] s, c, input logic kd);
    @(negedge clk_i);
    {rst_n_i, test_reset_i, sig_word_i, page0_sum_i} = {1'b0, t, s, c};
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    chk(debug_en_o, 1'b0);
    kernel_done_i = kd;
    @(negedge clk_i);
    kernel_done_i = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask
  task flash_op(input logic i);
    @(negedge clk_i);
    erase_i = 1'b1;
    @(negedge clk_i);
    erase_i = 1'b0;
    repeat (4) @(negedge clk_i);
    irq_i = i;
    @(negedge clk_i);
    irq_i = 1'b0;
    for (n = 1; n < 200 && flash_busy_o === 1'b1; n++) @(negedge clk_i);
  endtask
  // ==========
  // scenarios
  task t_boot;
    boot(1'b0, 32'h1, 32'h2, 1'b0);
    seen = 1'b0;
    repeat (130) @(negedge clk_i) seen |= wdog_rst_o;
    chk(seen, 1'b1);
    boot(1'b0, 32'h1, 32'h2, 1'b1);
    chk(download_o, 1'b1);
    sig_word_i = `SIG_VALUE;
    seen = 1'b0;
    repeat (130) @(negedge clk_i) seen |= wdog_rst_o;
    chk(seen, 1'b0);
    chk({download_o, user_run_o}, 2'b10);
    boot(1'b0, 32'h5A5A0F0F, 32'h5A5A0F0F, 1'b1);
    chk(user_run_o, 1'b1);
    boot(1'b1, 32'h1, 32'h2, 1'b1);
    chk({user_run_o, debug_en_o}, 2'b11);
    chk(kernel_base_o, `KERNEL_BASE);
    boot(1'b0, `SIG_VALUE, 32'h0, 1'b1);
    chk(user_run_o, 1'b1);
  endtask
  task t_timing;
    run(`OP_ALU, 5'h00, 1'b1, 3'h0, 1);
    run(`OP_ALU, 5'h00, 1'b0, 3'h0, 2);
    run(`OP_ALU, 5'h00, 1'b0, 3'h1, 1);
    run(`OP_BRANCH, 5'h00, 1'b0, 3'h0, 7);
    run(`OP_BRANCH, 5'h00, 1'b0, 3'h2, 2);
    run(`OP_LD, 5'h00, 1'b1, 3'h0, 4);
    run(`OP_LD, 5'h00, 1'b0, 3'h1, 4);
    run(`OP_LDH, 5'h00, 1'b1, 3'h0, 3);
    run(`OP_LDM, 5'h10, 1'b1, 3'h0, 49);
    run(`OP_LDM, 5'h02, 1'b0, 3'h0, 8);
    // each write: timer load pulse and done flop add two cycles
    run(`OP_STRH, 5'h00, 1'b1, 3'h0, 2 + (W + 2));
    run(`OP_STR, 5'h00, 1'b1, 3'h0, 2 + 2 * (W + 2));
    run(`OP_STM, 5'h02, 1'b1, 3'h0, 3 + 4 * (W + 2));
  endtask
  task t_flash;
    flash_op(1'b0);
    chk((n > 40) && (n < 50), 1'b1);
    fork
      flash_op(1'b0);
      issue(`OP_ALU, 5'h00, 1'b1, 3'h0);
    join
    chk(lat > 16'd40, 1'b1);
    flash_op(1'b1);
    chk((n > 7) && (n < 13), 1'b1);
    run(`OP_ALU, 5'h00, 1'b1, 3'h0, 1);
  endtask
  task t_mmr;
    macc(1'b1, 32'hFFFFF008, 32'hCAFEF00D, 1'b0);
    macc_rd(32'hFFFFF008, 1'b0, 32'hCAFEF00D);
    chk(mmr_hit_o, 1'b1);
    macc_rd(32'hFFFFF008, 1'b1, 32'h0000F00D);
    macc(1'b1, 32'hFFFFF008, 32'hBEEF1234, 1'b1);
    macc_rd(32'hFFFFF008, 1'b0, 32'h00001234);
    macc(1'b0, 32'h00001000, 32'h0, 1'b0);
    chk(mmr_hit_o, 1'b0);
  endtask
  task macc_rd(input logic [31:0] a, input logic h, input logic [31:0] e);
    macc(1'b0, a, 32'h0, h);
    chk(mmr_rdata_o, e);
  endtask
  // ==========
  // run and hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end
  initial begin
    t_boot;
    t_timing;
    t_flash;
    t_mmr;
    finish_test;
  end
endmodule // flash_fetch_boot_mmr_access_tb
`default_nettype wire
